// [core/pcs_core.sv]
`timescale 1ns/1ns

module pcs_core
  import pcs_pkg::*;
(
  core_clk,
  reset_n,
  seq_req,
  pcl_wr,
  pcl_wdata,
  latch_wr,
  latch_wdata,
  ptr_wr,
  ptr_wdata,
  bank_bit,
  data_req,
  mem_rdata,
  pc,
  pc_low_byte_reg,
  pc_high_bits_latch,
  indirect_pointer_reg,
  mem_addr,
  mem_wr,
  mem_wdata,
  data_rdata
);
  input wire logic core_clk;
  input wire logic reset_n;
  input wire pcs_seq_req_t seq_req;
  input wire logic pcl_wr;
  input wire logic [BYTE_W-1:0] pcl_wdata;
  input wire logic latch_wr;
  input wire logic [HI_W-1:0] latch_wdata;
  input wire logic ptr_wr;
  input wire logic [BYTE_W-1:0] ptr_wdata;
  input wire logic bank_bit;
  input wire pcs_data_req_t data_req;
  input wire logic [BYTE_W-1:0] mem_rdata;
  output logic [PC_W-1:0] pc;
  output logic [BYTE_W-1:0] pc_low_byte_reg;
  output logic [HI_W-1:0] pc_high_bits_latch;
  output logic [BYTE_W-1:0] indirect_pointer_reg;
  output logic [EA_W-1:0] mem_addr;
  output logic mem_wr;
  output logic [BYTE_W-1:0] mem_wdata;
  output logic [BYTE_W-1:0] data_rdata;

  // ****************************************
  // sequencing state
  // ****************************************
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic [HI_W-1:0] latch_q;
  logic [HI_W-1:0] latch_d;
  logic [PC_W-1:0] stk_q [STK_DEPTH];
  logic [PC_W-1:0] stk_d [STK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic [SP_W-1:0] sp_d;

  // ****************************************
  // indirect access state
  // ****************************************
  logic [BYTE_W-1:0] ptr_q;
  logic [BYTE_W-1:0] ptr_d;
  logic [EA_W-1:0] addr_q;
  logic [EA_W-1:0] addr_d;
  logic self_q;
  logic self_d;
  logic wr_q;
  logic wr_d;
  logic [BYTE_W-1:0] wdata_q;
  logic [BYTE_W-1:0] wdata_d;
  logic [BYTE_W-1:0] rdata_q;
  logic [BYTE_W-1:0] rdata_d;

  // ****************************************
  // decode nets
  // ****************************************
  logic do_push;
  logic do_pop;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] branch_pc;
  logic [PC_W-1:0] push_val;
  logic [PC_W-1:0] stk_top;
  logic [SP_W-1:0] sp_above;
  logic [SP_W-1:0] sp_below;
  logic port_hit;
  logic bank_unused;

  // ****************************************
  // helper functions
  // ****************************************
  // push on call and on interrupt vectoring
  function automatic logic op_pushes(input pcs_op_t op);
    op_pushes = (op == PCS_OP_CALL) || (op == PCS_OP_VECTOR);
  endfunction

  // pop on every return flavour
  function automatic logic op_pops(input pcs_op_t op);
    op_pops = (op == PCS_OP_RET) || (op == PCS_OP_RET_LIT) || (op == PCS_OP_RET_INT);
  endfunction

  function automatic logic [SP_W-1:0] sp_step(input logic [SP_W-1:0] p, input logic up);
    sp_step = up ? p + SP_ONE : p - SP_ONE;
  endfunction

  // jump target page from latch bits 4..3 only
  function automatic logic [PC_W-1:0] branch_addr(
    input logic [HI_W-1:0] hi,
    input logic [JMP_W-1:0] tgt
  );
    branch_addr = {hi[HI_W-1:LATCH_JMP_LSB], tgt};
  endfunction

  // low byte write takes all five latch bits
  function automatic logic [PC_W-1:0] low_write_addr(
    input logic [HI_W-1:0] hi,
    input logic [BYTE_W-1:0] lo
  );
    low_write_addr = {hi, lo};
  endfunction

  // the port address itself, seen as a location
  function automatic logic selects_port(input logic [BYTE_W-1:0] a);
    selects_port = (a == IND_PORT_ADDR);
  endfunction

  // ****************************************
  // sequencing decode
  // ****************************************
  always_comb begin
    do_push = op_pushes(seq_req.op);
    do_pop = op_pops(seq_req.op);
    pc_inc = pc_q + PC_ONE;
    branch_pc = branch_addr(latch_q, seq_req.target);
    sp_above = sp_step(sp_q, 1'b1);
    sp_below = sp_step(sp_q, 1'b0);
    stk_top = stk_q[sp_below];
    // vectoring saves the interrupted address itself
    push_val = pc_inc;
    if (seq_req.op == PCS_OP_VECTOR) begin
      push_val = pc_q;
    end
  end

  // ****************************************
  // program counter
  // ****************************************
  always_comb begin
    pc_d = pc_q;
    unique case (seq_req.op)
      PCS_OP_STEP: begin
        pc_d = pc_inc;
      end
      PCS_OP_HOLD: begin
        pc_d = pc_q;
      end
      PCS_OP_JUMP, PCS_OP_CALL: begin
        pc_d = branch_pc;
      end
      PCS_OP_VECTOR: begin
        pc_d = seq_req.vector;
      end
      PCS_OP_RET, PCS_OP_RET_LIT, PCS_OP_RET_INT: begin
        pc_d = stk_top;
      end
    endcase
    // software low-byte write wins over the op
    if (pcl_wr) begin
      pc_d = low_write_addr(latch_q, pcl_wdata);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ****************************************
  // high-bits latch
  // ****************************************
  // pushes and pops never touch the latch
  always_comb begin
    latch_d = latch_q;
    if (latch_wr) begin
      latch_d = latch_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= HI_RESET;
    end else begin
      latch_q <= latch_d;
    end
  end

  // ****************************************
  // return stack
  // ****************************************
  // pointer and stack never leave the block
  always_comb begin
    stk_d = stk_q;
    sp_d = sp_q;
    if (do_push) begin
      stk_d[sp_q] = push_val;
      sp_d = sp_above;
    end else if (do_pop) begin
      sp_d = sp_below;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_q <= SP_RESET;
      for (int i = 0; i < STK_DEPTH; i++) begin
        stk_q[i] <= PC_RESET;
      end
    end else begin
      sp_q <= sp_d;
      for (int i = 0; i < STK_DEPTH; i++) begin
        stk_q[i] <= stk_d[i];
      end
    end
  end

  // ****************************************
  // indirect pointer
  // ****************************************
  always_comb begin
    ptr_d = ptr_q;
    if (ptr_wr) begin
      ptr_d = ptr_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q <= BYTE_ZERO;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // ****************************************
  // effective address
  // ****************************************
  // bank bit has no effect in this family
  assign bank_unused = bank_bit;

  always_comb begin
    port_hit = selects_port(data_req.addr);
    addr_d = {1'b0, data_req.addr};
    self_d = 1'b0;
    if (port_hit) begin
      addr_d = {1'b0, ptr_q};
      self_d = selects_port(ptr_q);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= {EA_W{1'b0}};
      self_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      self_q <= self_d;
    end
  end

  // ****************************************
  // write path
  // ****************************************
  // self-indirect write is dropped
  always_comb begin
    wr_d = data_req.wr & ~self_d;
    wdata_d = data_req.wdata;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= 1'b0;
      wdata_q <= BYTE_ZERO;
    end else begin
      wr_q <= wr_d;
      wdata_q <= wdata_d;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // self-indirect read answers zero
  always_comb begin
    rdata_d = mem_rdata;
    if (self_q) begin
      rdata_d = BYTE_ZERO;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pc = pc_q;
  assign pc_low_byte_reg = pc_q[BYTE_W-1:0];
  assign pc_high_bits_latch = latch_q;
  assign indirect_pointer_reg = ptr_q;
  assign mem_addr = addr_q;
  assign mem_wr = wr_q;
  assign mem_wdata = wdata_q;
  assign data_rdata = rdata_q;

endmodule

// [shared/pcs_pkg.sv]
package pcs_pkg;

  // ****************************************
  // widths and sizes
  // ****************************************
  localparam int PC_W = 13;
  localparam int BYTE_W = 8;
  localparam int HI_W = 5;
  localparam int STK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int EA_W = 9;
  localparam int JMP_W = 11;

  // ****************************************
  // field positions and constants
  // ****************************************
  localparam int LATCH_JMP_LSB = 3;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [SP_W-1:0] SP_ONE = 3'h1;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [HI_W-1:0] HI_RESET = 5'h00;
  localparam logic [BYTE_W-1:0] IND_PORT_ADDR = 8'h00;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;

  // ****************************************
  // sequencing operations from the decoder
  // ****************************************
  typedef enum logic [2:0] {
    PCS_OP_STEP = 3'b000,
    PCS_OP_JUMP = 3'b001,
    PCS_OP_CALL = 3'b010,
    PCS_OP_RET = 3'b011,
    PCS_OP_RET_LIT = 3'b100,
    PCS_OP_RET_INT = 3'b101,
    PCS_OP_VECTOR = 3'b110,
    PCS_OP_HOLD = 3'b111
  } pcs_op_t;

  typedef struct packed {
    pcs_op_t op;
    logic [JMP_W-1:0] target;
    logic [PC_W-1:0] vector;
  } pcs_seq_req_t;

  typedef struct packed {
    logic wr;
    logic [BYTE_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } pcs_data_req_t;

endpackage

// [testbench/pcs_chk.sv]
`timescale 1ns/1ns
module pcs_chk
  import pcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire pcs_seq_req_t seq_req,
  input wire pcs_data_req_t data_req,
  input wire logic pcl_wr,
  input wire logic latch_wr,
  input wire logic [7:0] pcl_wdata,
  input wire logic [4:0] pc_high_bits_latch,
  input wire logic [12:0] pc,
  input wire logic [7:0] indirect_pointer_reg,
  input wire logic [8:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [7:0] data_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic ind = data_req.addr == 8'h00;
  wire logic self_ind = ind && indirect_pointer_reg == 8'h00;
  a_pcl_load: assert property (
    pcl_wr |=> pc == {$past(pc_high_bits_latch), $past(pcl_wdata)}) else $error("pcl");
  a_jump_load: assert property (
    !pcl_wr && seq_req.op inside {PCS_OP_JUMP, PCS_OP_CALL}
    |=> pc == {$past(pc_high_bits_latch[4:3]), $past(seq_req.target)}) else $error("jump");
  a_pc_step: assert property (
    !pcl_wr && seq_req.op == PCS_OP_STEP |=> pc == $past(pc) + 13'h1) else $error("step");
  a_ret_restore: assert property (
    !pcl_wr && seq_req.op == PCS_OP_CALL ##1 !pcl_wr && seq_req.op == PCS_OP_RET
    |=> pc == $past(pc, 2) + 13'h1) else $error("ret");
  a_latch_keep: assert property (
    !latch_wr |=> $stable(pc_high_bits_latch)) else $error("latch");
  a_ind_addr: assert property (
    ind && !self_ind |=> mem_addr == {1'h0, $past(indirect_pointer_reg)}) else $error("ind");
  a_self_write: assert property (self_ind |=> !mem_wr) else $error("sw");
  a_self_read: assert property (self_ind |-> ##2 data_rdata == 8'h00) else $error("sr");
endmodule

// [testbench/pcs_core_tb_top.sv]
`timescale 1ns/1ns
module pcs_core_tb_top
  import pcs_pkg::*;
();
  logic core_clk = 1'h0, reset_n = 1'h0, pcl_wr = 1'h0, ptr_wr = 1'h0;
  logic latch_wr = 1'h1, bank_bit = 1'h1, mem_wr, v;
  logic [7:0] pcl_wdata = 8'h45, ptr_wdata, mem_rdata, mem_wdata, data_rdata;
  logic [7:0] pc_low_byte_reg, indirect_pointer_reg;
  logic [4:0] latch_wdata = 5'h1b, pc_high_bits_latch;
  logic [12:0] pc, exp_pc, stk [8];
  logic [8:0] mem_addr;
  logic [2:0] sp = 3'h0;
  pcs_seq_req_t seq_req = '{PCS_OP_HOLD, 11'h0, 13'h4};
  pcs_data_req_t data_req = '0;
  int error_cnt = 0, num_checks = 0;
  always #10 core_clk = ~core_clk;
  pcs_core uut (.*);
  pcs_mem_model u_mem (.*);
  initial #4000 results(1);
  task automatic seq(input pcs_op_t o, input int t, n);
    seq_req = '{o, 11'(t), 13'h4};
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input logic [12:0] e, g);
    num_checks++;
    if (g !== e) error_cnt++;
    if (g !== e) $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
  endtask
  task automatic results(input int to);
    error_cnt += to;
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    seq(PCS_OP_HOLD, 0, 10);
    chk(13'h0, pc);
    reset_n = 1'h1;
    seq(PCS_OP_HOLD, 0, 1);
    latch_wr = 1'h0;
    seq(PCS_OP_JUMP, 'h123, 1);
    chk(13'h1923, pc);
    seq(PCS_OP_STEP, 0, 1);
    chk(13'h1924, pc);
    pcl_wr = 1'h1;
    seq(PCS_OP_HOLD, 0, 1);
    pcl_wr = 1'h0;
    chk(13'h1b45, pc);
    chk(13'h45, pc_low_byte_reg);
    $display("pc load test done");
    exp_pc = 13'h1b45;
    for (int i = 0; i < 9; i++) begin
      v = i == 4;
      stk[sp] = v ? exp_pc : exp_pc + 13'h1;
      sp++;
      exp_pc = v ? 13'h4 : {2'h3, 11'(i * 16)};
      seq(v ? PCS_OP_VECTOR : PCS_OP_CALL, i * 16, 1);
      chk(exp_pc, pc);
    end
    for (int i = 0; i < 9; i++) begin
      sp--;
      seq(pcs_op_t'(3 + i % 3), 0, 1);
      chk(stk[sp], pc);
    end
    chk(13'h1b, pc_high_bits_latch);
    $display("stack test done");
    for (int k = 1; k >= 0; k--) begin
      ptr_wdata = k ? 8'h30 : 8'h00;
      ptr_wr = 1'h1;
      seq(PCS_OP_HOLD, 0, 1);
      ptr_wr = 1'h0;
      chk(k ? 13'h30 : 13'h0, indirect_pointer_reg);
      data_req = '{1'h1, 8'h00, 8'h5a};
      seq(PCS_OP_HOLD, 0, 1);
      chk(13'(k), mem_wr);
      if (k) chk(13'h30, mem_addr);
      if (k) chk(13'h5a, mem_wdata);
      data_req = '0;
      seq(PCS_OP_HOLD, 0, 2);
      chk(k ? 13'h5a : 13'h0, data_rdata);
    end
    $display("data test done");
    reset_n = 1'h0;
    #1;
    chk(13'h0, pc);
    results(0);
  end
endmodule
bind pcs_core pcs_chk u_chk (.*);

// [testbench/pcs_mem_model.sv]
`timescale 1ns/1ns
module pcs_mem_model (
  input wire logic core_clk,
  input wire logic [8:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [512];
  assign mem_rdata = ram[mem_addr];
  always @(posedge core_clk) if (mem_wr) ram[mem_addr] <= mem_wdata;
endmodule
